/* core/cms_sequencer.sv */
/*
  Mode and charge-cycle sequencer: Hi-Z, sleep, over-voltage, supply sag,
  termination and battery detection, with a small register port.
  Assumes monitor inputs are asynchronous comparator levels.
*/
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module cms_sequencer #(
  parameter int unsigned RESUME_CYC = cms_pkg::RESUME_CYC,
  parameter int unsigned PULSE_CYC  = cms_pkg::PULSE_CYC,
  parameter int unsigned TERM_CYC   = cms_pkg::TERM_CYC,
  parameter int unsigned SINK_CYC   = cms_pkg::SINK_CYC,
  parameter int unsigned SRC_CYC    = cms_pkg::SRC_CYC
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire cms_pkg::cms_mon_t      mon_async,
  input  wire logic [cms_pkg::AW-1:0] reg_addr,
  input  wire logic [cms_pkg::DW-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [cms_pkg::DW-1:0] reg_rdata,
  output logic                        hiz_mode,
  output logic                        converter_on,
  output logic                        short_current_en,
  output logic                        detect_sink_en,
  output logic                        current_reduce,
  output logic                        input_cut,
  output logic                        timer_extend,
  output logic                        safety_timer_clr,
  output logic                        params_reset,
  output logic                        stat_pulse,
  output logic                        int_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchroniser

  cms_pkg::cms_mon_t mon_m_q;
  cms_pkg::cms_mon_t mon_s;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mon_m_q <= '0;
      mon_s   <= '0;
    end else begin
      mon_m_q <= mon_async;
      mon_s   <= mon_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  cms_pkg::cms_ctrl_t  ctrl_q;
  cms_pkg::cms_state_t state_q;
  cms_pkg::cms_state_t state_d;
  logic [31:0]         cnt_q;
  logic [31:0]         term_cnt_q;
  logic [31:0]         pulse_cnt_q;
  logic [2:0]          fault_q;
  logic                absent_q;
  logic                chg_prev_q;
  logic                src_on_q;
  logic                src_on_d;
  logic                sag_q;
  logic                hiz_cond;
  logic                restart;
  logic                term_cond;
  logic                det_abort;
  logic                pulse_start;
  logic                sink_fail;
  logic                charging;
  logic [1:0]          phase;

  ////////////////////////////////////////////////////////////////////////////
  // Condition decode

  assign hiz_cond = !mon_s.vin_above_uvlo || ctrl_q.high_impedance_request
                    || mon_s.disable_pin;
  assign restart  = (reg_wr && reg_addr == cms_pkg::ADDR_CTRL && reg_wdata[5])
                    || (ctrl_q.charge_enable != chg_prev_q);
  assign term_cond = ctrl_q.cutoff_allow && mon_s.loop_cv && mon_s.ibat_at_term
                     && mon_s.vbat_above_rch && !mon_s.loop_other
                     && !mon_s.input_power_limit_loop && !mon_s.ts_warm && !mon_s.ts_cool
                     && !ctrl_q.half_current_select;
  assign det_abort = !ctrl_q.cutoff_allow || !ctrl_q.charge_enable;
  assign sink_fail = state_q == cms_pkg::ST_SINK && !mon_s.vbat_above_detect;
  assign charging  = state_d == cms_pkg::ST_CHARGE && ctrl_q.charge_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl_q     <= cms_pkg::CTRL_RST;
      chg_prev_q <= cms_pkg::CTRL_RST.charge_enable;
    end else begin
      chg_prev_q <= ctrl_q.charge_enable;
      if (reg_wr && reg_addr == cms_pkg::ADDR_CTRL) begin
        ctrl_q             <= reg_wdata;
        ctrl_q.reset_cycle <= 1'b0;
        ctrl_q.rsvd        <= '0;
      end
    end
  end

  always_comb begin
    phase = cms_pkg::PH_READY;
    case (state_q)
      cms_pkg::ST_CHARGE, cms_pkg::ST_SINK, cms_pkg::ST_SRC: phase = cms_pkg::PH_CHARGING;
      cms_pkg::ST_DONE:                   phase = cms_pkg::PH_DONE;
      cms_pkg::ST_OVP, cms_pkg::ST_SLEEP: phase = cms_pkg::PH_FAULT;
      default:                            phase = cms_pkg::PH_READY;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (reg_addr == cms_pkg::ADDR_CTRL) begin
        reg_rdata <= ctrl_q;
      end else if (reg_addr == cms_pkg::ADDR_STAT) begin
        reg_rdata <= {sag_q, state_q, 2'h0, phase};
      end else if (reg_addr == cms_pkg::ADDR_FAULT) begin
        reg_rdata <= {5'h00, fault_q};
      end else begin
        reg_rdata <= '0;
      end
    end else begin
      reg_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode state machine

  always_comb begin
    state_d = state_q;
    if (hiz_cond) begin
      state_d = cms_pkg::ST_HIZ;
    end else if (state_q == cms_pkg::ST_HIZ) begin
      state_d = cms_pkg::ST_RESUME;
    end else if (mon_s.vin_ovp) begin
      state_d = cms_pkg::ST_OVP;
    end else if (!mon_s.vin_above_sleep) begin
      state_d = cms_pkg::ST_SLEEP;
    end else begin
      case (state_q)
        cms_pkg::ST_RESUME: begin
          if (cnt_q == RESUME_CYC - 32'h1) state_d = cms_pkg::ST_CHARGE;
        end
        cms_pkg::ST_OVP, cms_pkg::ST_SLEEP: state_d = cms_pkg::ST_CHARGE;
        cms_pkg::ST_CHARGE: begin
          if (term_cond && term_cnt_q == TERM_CYC - 32'h1) begin
            state_d = cms_pkg::ST_SINK;
          end
        end
        cms_pkg::ST_SINK: begin
          if (det_abort || restart) begin
            state_d = cms_pkg::ST_CHARGE;
          end else if (!mon_s.vbat_above_detect) begin
            state_d = cms_pkg::ST_SRC;
          end else if (cnt_q == SINK_CYC - 32'h1) begin
            state_d = absent_q ? cms_pkg::ST_CHARGE : cms_pkg::ST_DONE;
          end
        end
        cms_pkg::ST_SRC: begin
          if (det_abort || restart) begin
            state_d = cms_pkg::ST_CHARGE;
          end else if (cnt_q == SRC_CYC - 32'h1) begin
            state_d = cms_pkg::ST_SINK;
          end
        end
        cms_pkg::ST_DONE: begin
          if (mon_s.vbat_below_recharge || restart) state_d = cms_pkg::ST_CHARGE;
        end
        default: state_d = state_q;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_q <= cms_pkg::ST_HIZ;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= (state_d != state_q) ? 32'h0 : cnt_q + 32'h1;
    end
  end

  // Termination deglitch; any restart also clears it
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      term_cnt_q <= '0;
    end else if (state_q == cms_pkg::ST_CHARGE && term_cond && !restart) begin
      term_cnt_q <= term_cnt_q + 32'h1;
    end else begin
      term_cnt_q <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Battery detection

  always_comb begin
    src_on_d = src_on_q;
    if (state_q != cms_pkg::ST_SRC) begin
      src_on_d = 1'b1;
    end else if (mon_s.vbat_at_src_hi) begin
      src_on_d = 1'b0;
    end else if (mon_s.vbat_at_src_lo) begin
      src_on_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      src_on_q <= 1'b1;
      absent_q <= 1'b0;
    end else begin
      src_on_q <= src_on_d;
      if (sink_fail) begin
        absent_q <= 1'b1;
      end else if (state_d == cms_pkg::ST_CHARGE) begin
        absent_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault code, sticky per kind

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      fault_q <= cms_pkg::FLT_NONE;
    end else begin
      if (fault_q == cms_pkg::FLT_SLEEP && state_q != cms_pkg::ST_SLEEP
          && reg_rd && reg_addr == cms_pkg::ADDR_FAULT) begin
        fault_q <= cms_pkg::FLT_NONE;
      end
      if (fault_q == cms_pkg::FLT_OVP && state_q != cms_pkg::ST_OVP) begin
        fault_q <= cms_pkg::FLT_NONE;
      end
      if (fault_q == cms_pkg::FLT_ABSENT && absent_q && state_d == cms_pkg::ST_CHARGE) begin
        fault_q <= cms_pkg::FLT_NONE;
      end
      // Setting wins over any clear in the same cycle
      if (state_d == cms_pkg::ST_OVP && state_q != cms_pkg::ST_OVP) begin
        fault_q <= cms_pkg::FLT_OVP;
      end else if (state_d == cms_pkg::ST_SLEEP && state_q != cms_pkg::ST_SLEEP) begin
        fault_q <= cms_pkg::FLT_SLEEP;
      end else if (sink_fail) begin
        fault_q <= cms_pkg::FLT_ABSENT;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status pulse

  assign pulse_start = (state_d == cms_pkg::ST_OVP && state_q != cms_pkg::ST_OVP)
                       || (state_d == cms_pkg::ST_SLEEP && state_q != cms_pkg::ST_SLEEP);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      stat_pulse  <= 1'b0;
      int_pulse   <= 1'b0;
      pulse_cnt_q <= '0;
    end else if (pulse_start && !stat_pulse) begin
      stat_pulse  <= 1'b1;
      int_pulse   <= 1'b1;
      pulse_cnt_q <= '0;
    end else if (stat_pulse) begin
      pulse_cnt_q <= pulse_cnt_q + 32'h1;
      if (pulse_cnt_q == PULSE_CYC - 32'h1) begin
        stat_pulse <= 1'b0;
        int_pulse  <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power stage controls

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      hiz_mode         <= 1'b1;
      converter_on     <= 1'b0;
      short_current_en <= 1'b0;
      detect_sink_en   <= 1'b0;
      safety_timer_clr <= 1'b0;
      params_reset     <= 1'b0;
    end else begin
      hiz_mode         <= state_d == cms_pkg::ST_HIZ;
      converter_on     <= charging;
      short_current_en <= (charging && !mon_s.vbat_above_short)
                          || (state_d == cms_pkg::ST_SRC && src_on_d);
      detect_sink_en   <= state_d == cms_pkg::ST_SINK;
      safety_timer_clr <= state_d == cms_pkg::ST_HIZ && state_q != cms_pkg::ST_HIZ;
      params_reset     <= sink_fail;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sag_q          <= 1'b0;
      current_reduce <= 1'b0;
      timer_extend   <= 1'b0;
      input_cut      <= 1'b0;
    end else begin
      sag_q          <= mon_s.input_power_limit_loop;
      current_reduce <= charging && mon_s.input_power_limit_loop;
      timer_extend   <= charging && mon_s.input_power_limit_loop && ctrl_q.timer_double;
      input_cut      <= charging && mon_s.die_hot
                        && (mon_s.loop_cc || mon_s.loop_cv);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  chk_hiz_conv_off: assert property (hiz_cond |=> hiz_mode && !converter_on)
    else $error("converter not off in hi-z");
  chk_hiz_timer_clr: assert property (
    (state_q != cms_pkg::ST_HIZ) ##1 (state_q == cms_pkg::ST_HIZ) |-> safety_timer_clr)
    else $error("safety timer not cleared on hi-z");
  chk_resume_delay: assert property (
    (state_q == cms_pkg::ST_RESUME && state_d == cms_pkg::ST_CHARGE)
      |-> cnt_q == RESUME_CYC - 32'h1)
    else $error("resume delay wrong");
  chk_fault_pulse: assert property (pulse_start && !stat_pulse |=> stat_pulse && int_pulse)
    else $error("fault pulse missing");
  chk_pulse_len: assert property (stat_pulse |-> pulse_cnt_q < PULSE_CYC)
    else $error("fault pulse too long");
  chk_sleep_hold: assert property (
    fault_q == cms_pkg::FLT_SLEEP && state_q == cms_pkg::ST_SLEEP
      |=> fault_q == cms_pkg::FLT_SLEEP)
    else $error("sleep fault cleared early");
  chk_sag_flag: assert property (mon_s.input_power_limit_loop |=> sag_q)
    else $error("sag flag not set");
  chk_term_block: assert property (
    (state_q == cms_pkg::ST_CHARGE && state_d == cms_pkg::ST_SINK)
      |-> !mon_s.input_power_limit_loop && ctrl_q.cutoff_allow && term_cnt_q == TERM_CYC - 32'h1)
    else $error("termination not qualified");
  chk_sink_len: assert property (
    (state_q == cms_pkg::ST_SINK && state_d == cms_pkg::ST_DONE)
      |-> cnt_q == SINK_CYC - 32'h1)
    else $error("sink phase length wrong");
  chk_src_len: assert property (
    (state_q == cms_pkg::ST_SRC && state_d == cms_pkg::ST_SINK && !det_abort)
      |-> cnt_q == SRC_CYC - 32'h1)
    else $error("source phase length wrong");

  cov_sleep: cover property (state_q == cms_pkg::ST_SLEEP ##1 state_q == cms_pkg::ST_CHARGE);
  cov_done: cover property (state_q == cms_pkg::ST_SINK ##1 state_q == cms_pkg::ST_DONE);
  cov_absent: cover property (state_q == cms_pkg::ST_SRC ##1 state_q == cms_pkg::ST_SINK);

endmodule : cms_sequencer

`default_nettype wire

/* core/cms_pkg.sv */
/*
  Constants and carrier types for the charger mode sequencer.
  Assumes a 250 MHz system clock and asynchronous monitor comparators.
*/
// Behaviour
// - Hi-Z on UVLO, request bit, disable pin
// - Entering Hi-Z clears safety timer
// - Resume charging about 110ms after Hi-Z
// - Sleep stops converter, one 128us pulse
// - Sleep exit clears phase, restarts charge
// - Sleep fault held until read and ended
// - Supply sag reduces current, sets flag
// - Sag blocks termination, extends doubled timer
// - Over-voltage stops converter, pulses, resumes after
// - Charge-enable bit gates charging, default on
// - Short-battery current until above short threshold
// - Die heat in CC or CV charging cuts input current
// - CV taper plus recharge level ends charge
// - Cutoff disabled means never terminate
// - Other loops, warm, cool, half current block
// - New cycle on recharge, POR, toggles, reset
// - Sink phase holding above threshold means done
// - Sink drop flags absence, resets parameters
// - Source phase hysteretic short-battery current
// - Alternate phases; found battery restarts charge
// - No detection when cutoff disabled
// - Sink phase lasts 250 ms
// - Source phase lasts 2 s
// - Termination deglitched for 32 ms
package cms_pkg;

  localparam int unsigned CLK_HZ      = 250_000_000;
  localparam int unsigned HZ_PER_MS   = 1000;
  localparam int unsigned HZ_PER_US   = 1_000_000;
  localparam int unsigned T_RESUME_MS = 110;
  localparam int unsigned T_PULSE_US  = 128;
  localparam int unsigned T_TERM_MS   = 32;
  localparam int unsigned T_SINK_MS   = 250;
  localparam int unsigned T_SRC_S     = 2;
  localparam int unsigned RESUME_CYC  = T_RESUME_MS * (CLK_HZ / HZ_PER_MS);
  localparam int unsigned PULSE_CYC   = T_PULSE_US * (CLK_HZ / HZ_PER_US);
  localparam int unsigned TERM_CYC    = T_TERM_MS * (CLK_HZ / HZ_PER_MS);
  localparam int unsigned SINK_CYC    = T_SINK_MS * (CLK_HZ / HZ_PER_MS);
  localparam int unsigned SRC_CYC     = T_SRC_S * CLK_HZ;

  localparam int unsigned AW = 2;
  localparam int unsigned DW = 8;
  localparam logic [AW-1:0] ADDR_CTRL  = 2'h0;
  localparam logic [AW-1:0] ADDR_STAT  = 2'h1;
  localparam logic [AW-1:0] ADDR_FAULT = 2'h2;

  localparam logic [1:0] PH_READY    = 2'h0;
  localparam logic [1:0] PH_CHARGING = 2'h1;
  localparam logic [1:0] PH_DONE     = 2'h2;
  localparam logic [1:0] PH_FAULT    = 2'h3;

  localparam logic [2:0] FLT_NONE   = 3'h0;
  localparam logic [2:0] FLT_OVP    = 3'h1;
  localparam logic [2:0] FLT_SLEEP  = 3'h2;
  localparam logic [2:0] FLT_ABSENT = 3'h3;

  typedef struct packed {
    logic [1:0] rsvd;
    logic       reset_cycle;
    logic       timer_double;
    logic       half_current_select;
    logic       cutoff_allow;
    logic       charge_enable;
    logic       high_impedance_request;
  } cms_ctrl_t;

  localparam cms_ctrl_t CTRL_RST = 8'h06;

  typedef struct packed {
    logic vin_above_uvlo;
    logic vin_above_sleep;
    logic vin_ovp;
    logic input_power_limit_loop;
    logic loop_cc;
    logic loop_cv;
    logic loop_other;
    logic die_hot;
    logic ts_warm;
    logic ts_cool;
    logic ibat_at_term;
    logic vbat_above_rch;
    logic vbat_below_recharge;
    logic vbat_above_short;
    logic vbat_above_detect;
    logic vbat_at_src_hi;
    logic vbat_at_src_lo;
    logic disable_pin;
  } cms_mon_t;

  typedef enum logic [2:0] {
    ST_HIZ    = 3'h0,
    ST_RESUME = 3'h1,
    ST_CHARGE = 3'h3,
    ST_SINK   = 3'h2,
    ST_SRC    = 3'h6,
    ST_DONE   = 3'h7,
    ST_SLEEP  = 3'h5,
    ST_OVP    = 3'h4
  } cms_state_t;

endpackage : cms_pkg

/* bench/cms_host_model.sv */
/*
  Host side of the sequencer: register port master and disable pin.
  Assumes one bench process calls its tasks, all after a rising edge.
*/
`timescale 1ns/100ps
`default_nettype none

module cms_host_model (
  input  wire logic                   clk_sys,
  input  wire logic [cms_pkg::DW-1:0] reg_rdata,
  output logic      [cms_pkg::AW-1:0] reg_addr,
  output logic      [cms_pkg::DW-1:0] reg_wdata,
  output logic                        reg_wr,
  output logic                        reg_rd,
  output logic                        disable_pin
);
  initial begin
    reg_addr    = 2'h0;
    reg_wdata   = 8'h00;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    disable_pin = 1'b0;
  end

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : rd

  // High forces Hi-Z, low permits charging
  task automatic set_disable(input logic v);
    @(posedge clk_sys);
    disable_pin <= v;
  endtask : set_disable
endmodule : cms_host_model
`default_nettype wire

/* bench/test_charger_mode_sequencer.sv */
/*
  Self-checking bench for the mode sequencer with shortened intervals.
  Assumes the host model drives the register port and disable pin.
*/
`timescale 1ns/100ps
`default_nettype none

module test_charger_mode_sequencer;
  localparam int RES = 20;
  localparam int PUL = 8;
  localparam int TRM = 10;
  localparam int SNK = 16;
  localparam int SRC = 40;

  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  cms_pkg::cms_mon_t mon = '0;
  cms_pkg::cms_mon_t mon_w;
  logic [1:0] a;
  logic [7:0] wd, rdat;
  logic wr, rd, dis;
  logic hiz, conv, shrt, sink, cred, icut, text, tclr, prst, stp, itp;
  int n_mismatch = 0;
  int comparisons = 0;
  int m_ctrl = 6;
  int k, w;
  logic seen;
  logic [31:0] seed = 32'h0000c22f;

  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  always_comb begin
    mon_w = mon;
    mon_w.disable_pin = dis;
  end

  cms_host_model i_host (.clk_sys(clk_sys), .reg_rdata(rdat), .reg_addr(a), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .disable_pin(dis));

  cms_sequencer #(.RESUME_CYC(RES), .PULSE_CYC(PUL), .TERM_CYC(TRM), .SINK_CYC(SNK),
    .SRC_CYC(SRC)) i_dut (.clk_sys(clk_sys), .rstn(rstn), .mon_async(mon_w), .reg_addr(a),
    .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .hiz_mode(hiz),
    .converter_on(conv), .short_current_en(shrt), .detect_sink_en(sink),
    .current_reduce(cred), .input_cut(icut), .timer_extend(text), .safety_timer_clr(tclr),
    .params_reset(prst), .stat_pulse(stp), .int_pulse(itp));

  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  task automatic cmp_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t output got %b exp %b", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic cmp_reg(input logic [1:0] ad, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] got;
    i_host.rd(ad, got);
    comparisons++;
    if ((got & m) !== exp) begin
      n_mismatch++;
      $display("ERROR %0t reg %0d got %h exp %h", $time, ad, got, exp);
    end
  endtask : cmp_reg

  task automatic wctrl(input logic [7:0] d);
    i_host.wr(cms_pkg::ADDR_CTRL, d);
    m_ctrl = int'(d & 8'h1f);
  endtask : wctrl

  // Waits for the event pulse and measures its width
  task automatic pulse_w();
    w = 0;
    for (k = 0; k < 10 && stp !== 1'b1; k++) @(negedge clk_sys);
    while (stp === 1'b1 && w < 50) begin
      cmp_bit(itp, 1'b1);
      w++;
      @(negedge clk_sys);
    end
    cmp_bit(w == PUL, 1'b1);
  endtask : pulse_w

  task automatic report_and_stop();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    tick(20000);
    n_mismatch++;
    report_and_stop();
  end

  ////////////////////////////////////////
  initial begin
    tick(10);
    rstn <= 1'b1;
    tick(3);
    cmp_bit(hiz, 1'b1);
    cmp_reg(cms_pkg::ADDR_CTRL, 8'hff, m_ctrl[7:0]);
    seed = xs(seed);
    i_host.wr(2'h3, seed[7:0]);
    cmp_reg(2'h3, 8'hff, 8'h00);
    cmp_reg(cms_pkg::ADDR_CTRL, 8'hff, m_ctrl[7:0]);
    seed = xs(seed);
    wctrl((seed[7:0] & 8'hf8) | 8'h06);
    cmp_reg(cms_pkg::ADDR_CTRL, 8'hff, m_ctrl[7:0]);
    wctrl(8'h06);
    $display("test reset done");
    @(posedge clk_sys);
    mon.vin_above_uvlo <= 1'b1;
    mon.vin_above_sleep <= 1'b1;
    mon.vbat_above_short <= 1'b1;
    tick(RES + 10);
    cmp_bit(conv, 1'b1);
    cmp_bit(shrt, 1'b0);
    cmp_reg(cms_pkg::ADDR_STAT, 8'h03, cms_pkg::PH_CHARGING);
    i_host.set_disable(1'b1);
    seen = 1'b0;
    repeat (6) begin
      @(negedge clk_sys);
      seen |= tclr;
    end
    cmp_bit(seen, 1'b1);
    cmp_bit(hiz, 1'b1);
    cmp_bit(conv, 1'b0);
    i_host.set_disable(1'b0);
    tick(RES);
    cmp_bit(conv, 1'b0);
    tick(8);
    cmp_bit(conv, 1'b1);
    wctrl(8'h07);
    tick(4);
    cmp_bit(hiz, 1'b1);
    wctrl(8'h06);
    tick(RES + 8);
    cmp_bit(conv, 1'b1);
    wctrl(8'h04);
    tick(4);
    cmp_bit(conv, 1'b0);
    wctrl(8'h06);
    tick(3);
    cmp_bit(conv, 1'b1);
    $display("test hiz done");
    @(posedge clk_sys);
    mon.vin_above_sleep <= 1'b0;
    pulse_w();
    cmp_bit(conv, 1'b0);
    cmp_reg(cms_pkg::ADDR_FAULT, 8'h07, cms_pkg::FLT_SLEEP);
    @(posedge clk_sys);
    mon.vin_above_sleep <= 1'b1;
    tick(6);
    cmp_bit(conv, 1'b1);
    cmp_reg(cms_pkg::ADDR_STAT, 8'h03, cms_pkg::PH_CHARGING);
    cmp_reg(cms_pkg::ADDR_FAULT, 8'h07, cms_pkg::FLT_SLEEP);
    cmp_reg(cms_pkg::ADDR_FAULT, 8'h07, cms_pkg::FLT_NONE);
    @(posedge clk_sys);
    mon.vin_ovp <= 1'b1;
    pulse_w();
    cmp_bit(conv, 1'b0);
    cmp_reg(cms_pkg::ADDR_FAULT, 8'h07, cms_pkg::FLT_OVP);
    @(posedge clk_sys);
    mon.vin_ovp <= 1'b0;
    tick(6);
    cmp_bit(conv, 1'b1);
    cmp_reg(cms_pkg::ADDR_FAULT, 8'h07, cms_pkg::FLT_NONE);
    $display("test input faults done");
    @(posedge clk_sys);
    mon.input_power_limit_loop <= 1'b1;
    mon.loop_cc <= 1'b1;
    mon.die_hot <= 1'b1;
    tick(5);
    cmp_bit(cred, 1'b1);
    cmp_bit(icut, 1'b1);
    cmp_bit(text, 1'b0);
    cmp_reg(cms_pkg::ADDR_STAT, 8'h80, 8'h80);
    wctrl(8'h16);
    tick(3);
    cmp_bit(text, 1'b1);
    mon.loop_cc <= 1'b0;
    mon.die_hot <= 1'b0;
    mon.loop_cv <= 1'b1;
    mon.ibat_at_term <= 1'b1;
    mon.vbat_above_rch <= 1'b1;
    mon.vbat_above_detect <= 1'b1;
    tick(TRM + 10);
    cmp_bit(sink, 1'b0);
    $display("test sag done");
    mon.input_power_limit_loop <= 1'b0;
    wctrl(8'h0e);
    tick(TRM + 10);
    cmp_bit(sink, 1'b0);
    wctrl(8'h02);
    tick(TRM + 10);
    cmp_bit(sink, 1'b0);
    cmp_bit(conv, 1'b1);
    wctrl(8'h06);
    tick(TRM - 3);
    cmp_bit(sink, 1'b0);
    tick(10);
    cmp_bit(sink, 1'b1);
    tick(SNK + 6);
    cmp_reg(cms_pkg::ADDR_STAT, 8'h03, cms_pkg::PH_DONE);
    cmp_bit(sink, 1'b0);
    @(posedge clk_sys);
    mon.vbat_below_recharge <= 1'b1;
    mon.vbat_above_detect <= 1'b0;
    tick(6);
    cmp_reg(cms_pkg::ADDR_STAT, 8'h03, cms_pkg::PH_CHARGING);
    @(posedge clk_sys);
    mon.vbat_below_recharge <= 1'b0;
    $display("test termination done");
    seen = 1'b0;
    repeat (TRM + 12) begin
      @(negedge clk_sys);
      seen |= prst;
    end
    cmp_bit(seen, 1'b1);
    cmp_reg(cms_pkg::ADDR_FAULT, 8'h07, cms_pkg::FLT_ABSENT);
    @(posedge clk_sys);
    mon.vbat_above_short <= 1'b0;
    mon.vbat_at_src_lo <= 1'b1;
    tick(5);
    cmp_bit(shrt, 1'b1);
    mon.vbat_at_src_lo <= 1'b0;
    mon.vbat_at_src_hi <= 1'b1;
    mon.vbat_above_detect <= 1'b1;
    tick(5);
    cmp_bit(shrt, 1'b0);
    for (k = 0; k < SRC + 10 && sink !== 1'b1; k++) @(negedge clk_sys);
    cmp_bit(sink, 1'b1);
    tick(SNK + 6);
    cmp_reg(cms_pkg::ADDR_FAULT, 8'h07, cms_pkg::FLT_NONE);
    cmp_reg(cms_pkg::ADDR_STAT, 8'h03, cms_pkg::PH_CHARGING);
    $display("test detection done");
    report_and_stop();
  end
endmodule : test_charger_mode_sequencer
`default_nettype wire
